// >>> dv/rtcats_i2c_master.sv
`timescale 1ns/1ps

module rtcats_i2c_master (
    output logic scl,
    output logic sda_m,
    input  wire  sda
);
    localparam realtime Q = 3.75;

    // Idle released, clock still between frames
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // Data set mid-low, sampled while high
    task automatic bit_x(input logic b, output logic r);
        #Q sda_m = b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
    endtask : bit_x

    task automatic start_c();
        #Q sda_m = 1'b1;
        #Q scl = 1'b1;
        #Q sda_m = 1'b0;
        #Q scl = 1'b0;
    endtask : start_c

    task automatic stop_c();
        #Q sda_m = 1'b0;
        #Q scl = 1'b1;
        #Q sda_m = 1'b1;
        #Q;
    endtask : stop_c

    task automatic pulses(input int n);
        repeat (n) begin
            #(2 * Q) scl = 1'b0;
            #(2 * Q) scl = 1'b1;
        end
    endtask : pulses

    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(v[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : wr_byte

    task automatic rd_byte(input logic mack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
        bit_x(!mack, r);
    endtask : rd_byte
endmodule : rtcats_i2c_master

// >>> dv/rtcats_sva.sv
`timescale 1ns/1ps

module rtcats_sva #(
    parameter int unsigned PULSE_CYCLES = 20
) (
    input logic core_clk,
    input logic reset,
    input logic scl,
    input logic sda_out,
    input logic sda_oe,
    input logic tick_1hz,
    input logic event_rise,
    input logic event_enable,
    input logic event_out_enable,
    input logic fout_on,
    input logic irq_n,
    input logic event_detect_out_n
);
    int unsigned low_cnt;
    logic        oe_at_rise;

    // Low stretch length
    always_ff @(posedge core_clk) begin
        if (reset || irq_n) low_cnt <= 0;
        else low_cnt <= low_cnt + 1;
    end

    // Level at clock rise
    always_ff @(posedge scl) oe_at_rise <= sda_oe;

    sequence low_run_s;
        !irq_n [*3];
    endsequence

    fall_tick_a:
        assert property (@(posedge core_clk) disable iff (reset) $fell(irq_n) |-> $past(tick_1hz, 3))
            else $error("fall without time update");
    fout_gate_a:
        assert property (@(posedge core_clk) disable iff (reset) $fell(irq_n) |-> !$past(fout_on, 2))
            else $error("fall while output gated");
    min_low_a:
        assert property (@(posedge core_clk) disable iff (reset) $fell(irq_n) |-> low_run_s)
            else $error("alarm low too briefly");
    pulse_width_a:
        assert property (@(posedge core_clk) disable iff (reset) $rose(irq_n) |-> low_cnt >= PULSE_CYCLES)
            else $error("alarm pulse too short");
    toggle_cause_a:
        assert property (@(posedge core_clk) disable iff (reset)
            $changed(event_detect_out_n) |-> $past(event_rise))
            else $error("toggle without event");
    toggle_gate_a:
        assert property (@(posedge core_clk) disable iff (reset)
            $changed(event_detect_out_n) |-> $past(event_enable) && $past(event_out_enable))
            else $error("toggle while disabled");
    open_drain_a:
        assert property (@(posedge core_clk) disable iff (reset) sda_out == 1'b0)
            else $error("data line driven high");
    sda_hold_a:
        assert property (@(negedge scl) disable iff (reset) sda_oe == oe_at_rise)
            else $error("data moved while clock high");
endmodule : rtcats_sva

// >>> dv/rtcats_top_tb.sv
`timescale 1ns/1ps

module rtcats_top_tb;
    localparam int         P  = 20;
    localparam logic [6:0] ID = 7'h52; // Arbitrary value
    logic                  core_clk = 1'b0;
    logic                  reset = 1'b1;
    logic                  tick_1hz = 1'b0;
    logic                  event_rise = 1'b0;
    logic                  event_enable = 1'b1;
    logic                  event_out_enable = 1'b1;
    logic                  fout_on = 1'b0;
    rtcats_pkg::rtcats_time_t time_now = '0;
    logic                  scl, sda_m, sda_out, sda_oe, irq_n, event_detect_out_n, ack, ev_out;
    logic [7:0]            d;
    logic [7:0]            mreg [0:25];
    int                    error_cnt = 0;
    int                    n_checks = 0;
    wire                   sda = sda_m & ~sda_oe;

    always #5 core_clk = ~core_clk;

    rtcats_top #(.SLAVE_ID(ID), .PULSE_CYCLES(P)) u_dut (.core_clk(core_clk), .reset(reset), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .tick_1hz(tick_1hz), .time_now(time_now),
        .event_rise(event_rise), .event_enable(event_enable), .event_out_enable(event_out_enable),
        .fout_on(fout_on), .irq_n(irq_n), .event_detect_out_n(event_detect_out_n));
    rtcats_i2c_master u_mst (.scl(scl), .sda_m(sda_m), .sda(sda));

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic e, input logic g);
        chk_byte({7'h00, e}, {7'h00, g});
    endtask : chk_bit

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    // Time live, rest from the model
    function automatic logic [7:0] exp_rd(input int a);
        if (a < 7) return time_now[55 - 8 * a -: 8];
        return mreg[a];
    endfunction : exp_rd

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        u_mst.start_c();
        u_mst.wr_byte({ID, 1'b0}, ack);
        chk_bit(1'b1, ack);
        u_mst.wr_byte(a, ack);
        chk_bit(1'b1, ack);
        u_mst.wr_byte(v, ack);
        chk_bit(1'b1, ack);
        u_mst.stop_c();
        cyc(8);
        // Flags clear on zero; time read-only
        if (a == 8'h07) mreg[7] = {v[7], 1'b0, mreg[7][5] & v[5], mreg[7][4] & v[4], 4'h0};
        else if (a == 8'h08 || (a >= 8'h0c && a <= 8'h13)) mreg[a] = v;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input int n);
        int p = a;
        u_mst.start_c();
        u_mst.wr_byte({ID, 1'b0}, ack);
        u_mst.wr_byte(a, ack);
        chk_bit(1'b1, ack);
        u_mst.start_c();
        u_mst.wr_byte({ID, 1'b1}, ack);
        chk_bit(1'b1, ack);
        for (int k = 0; k < n; k++) begin
            u_mst.rd_byte(k < n - 1, d);
            chk_byte(exp_rd(p) & ((p == 7) ? 8'hb0 : 8'hff), d & ((p == 7) ? 8'hb0 : 8'hff));
            if (p == 7 && mreg[7][7]) mreg[7][4] = 1'b0;
            p = (p == 25) ? 0 : p + 1;
        end
        u_mst.stop_c();
        cyc(8);
    endtask : reg_rd

    task automatic do_tick(input int wid);
        logic hit;
        logic any;
        hit = mreg[8][6] & ~fout_on;
        any = 1'b0;
        for (int k = 0; k < 6; k++) begin
            if (mreg[12 + k][7]) begin
                any = 1'b1;
                if (mreg[12 + k][6:0] !== time_now[54 - 8 * ((k == 5) ? 6 : k) -: 7]) hit = 1'b0;
            end
        end
        hit = hit & any;
        tick_1hz = 1'b1;
        cyc(1);
        tick_1hz = 1'b0;
        cyc(3);
        chk_bit(~hit, irq_n);
        if (hit) mreg[7][4] = 1'b1;
        if (hit && wid > 0) begin
            cyc(wid - 2);
            chk_bit(1'b0, irq_n);
            cyc(1);
            chk_bit(1'b1, irq_n);
        end
    endtask : do_tick

    task automatic do_event();
        logic take;
        take = event_enable & ~mreg[7][5];
        event_rise = 1'b1;
        cyc(1);
        event_rise = 1'b0;
        cyc(1);
        if (take) begin
            for (int k = 0; k < 6; k++) mreg[20 + k] = exp_rd(k);
            mreg[7][5] = 1'b1;
            if (event_out_enable) ev_out = ~ev_out;
        end
        chk_bit(ev_out, event_detect_out_n);
    endtask : do_event

    task automatic set_time();
        time_now = 56'({$urandom, $urandom} & 56'h7f7f7f7f7f7f7f);
    endtask : set_time

    // Hang guard
    initial begin
        #500000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        d = 8'($urandom(32'h8fd559b6));
        for (int k = 0; k < 26; k++) mreg[k] = 8'h00;
        ev_out = 1'b1;
        fork
            u_mst.pulses(4);
            u_mst.stop_c();
        join_none
        repeat (12) @(posedge core_clk);
        #1 reset = 1'b0;
        u_mst.pulses(3);
        set_time();
        u_mst.start_c();
        u_mst.wr_byte({ID, 1'b1}, ack);
        chk_bit(1'b1, ack);
        u_mst.rd_byte(1'b0, d);
        chk_byte(time_now.sec, d);
        u_mst.stop_c();
        // Foreign id gets no answer
        u_mst.start_c();
        u_mst.wr_byte({ID ^ 7'h01, 1'b0}, ack);
        chk_bit(1'b0, ack);
        u_mst.stop_c();
        reg_wr(8'h12, 8'($urandom));
        reg_wr(8'h13, 8'($urandom));
        reg_wr(8'h00, 8'h3c);
        event_enable = 1'b0;
        do_event();
        event_enable = 1'b1;
        do_event();
        set_time();
        do_event();
        reg_rd(8'h07, 7);
        reg_rd(8'h12, 11);
        reg_wr(8'h07, 8'h00);
        reg_rd(8'h14, 6);
        event_out_enable = 1'b0;
        set_time();
        do_event();
        // Single alarm on minutes
        reg_wr(8'h0d, {1'b1, time_now.min[6:0]});
        reg_wr(8'h08, 8'h40);
        do_tick(0);
        cyc(30);
        chk_bit(1'b0, irq_n);
        reg_rd(8'h07, 1);
        reg_wr(8'h07, 8'h80);
        chk_bit(1'b1, irq_n);
        fout_on = 1'b1;
        do_tick(0);
        fout_on = 1'b0;
        do_tick(0);
        reg_rd(8'h07, 1);
        chk_bit(1'b1, irq_n);
        reg_rd(8'h07, 1);
        reg_wr(8'h08, 8'hc0);
        do_tick(P);
        do_tick(P);
        // Random enable subsets
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 6; k++)
                reg_wr(8'(12 + k), {1'($urandom), ($urandom % 2) ? time_now[54 - 8 * ((k == 5) ? 6 : k) -: 7]
                    : 7'($urandom)});
            do_tick(P);
        end
        print_verdict();
    end
endmodule : rtcats_top_tb

bind rtcats_top rtcats_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (.core_clk(core_clk), .reset(reset), .scl(scl),
    .sda_out(sda_out), .sda_oe(sda_oe), .tick_1hz(tick_1hz), .event_rise(event_rise), .event_enable(event_enable),
    .event_out_enable(event_out_enable), .fout_on(fout_on), .irq_n(irq_n), .event_detect_out_n(event_detect_out_n));

// >>> rtl/rtcats_pkg.sv
package rtcats_pkg;

    // Running time from the time counters
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
        logic [7:0] wday;
    } rtcats_time_t;

    // One register write handed across domains
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } rtcats_acc_t;

    // Serial slave states
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_ID     = 6'b000010,
        ST_ADDR   = 6'b000100,
        ST_WDATA  = 6'b001000,
        ST_RDATA  = 6'b010000,
        ST_IGNORE = 6'b100000
    } rtcats_state_t;

endpackage : rtcats_pkg

// >>> rtl/rtcats_regs.svh
// What this block does
// - Alarm byte top bit enables its comparison
// - Alarm fires when all enabled bytes match
// - Single mode: flag set, output held low
// - Repetitive mode: pulse and flag every match
// - Repetitive pulse is low for 250 ms
// - Writing zero to alarm flag clears it
// - Auto-clear bit set: status read clears flag
// - Minute-level matches fire at seconds rollover; code fires on every tick while enabled bytes match
// - Control bit six enables, seven selects repeat
// - Two retained read/write user bytes
// - Event rise captures time, flags, toggles output
// - Stamp holds six fields, no weekday
// - Only first event after flag clear captured
// - Stamp never cleared by access or reset
// - Slave only, master clocks, MSB first
// - Data changes on low clock; else START/STOP
// - Ignore traffic until START; none at power-up
// - STOP returns interface to idle
// - Slave acks id, address, write data bytes
// - Upper seven id bits must match exactly
// - Last id bit: one read, zero write
// - Word address byte; pointer resets to zero
// - Read pointer increments, wraps after stamps
`ifndef RTCATS_REGS_SVH
`define RTCATS_REGS_SVH

// Timing
`define RTC_CLK_KHZ      100000
`define RTC_PULSE_MS     250
`define RTC_PULSE_CYCLES (`RTC_PULSE_MS * `RTC_CLK_KHZ)
`define RTC_PULSE_W      25

// Register addresses
`define RTC_ADDR_SEC     8'h00
`define RTC_ADDR_WDAY    8'h06
`define RTC_ADDR_STATUS  8'h07
`define RTC_ADDR_INT     8'h08
`define RTC_ADDR_ALM0    8'h0c
`define RTC_ADDR_ALM5    8'h11
`define RTC_ADDR_USER0   8'h12
`define RTC_ADDR_USER1   8'h13
`define RTC_ADDR_STAMP0  8'h14
`define RTC_ADDR_LAST    8'h19

// Field positions and reset values
`define RTC_ST_AUTO_CLEAR_ON_READ      7
`define RTC_ST_EVT       5
`define RTC_ST_ALM       4
`define RTC_INT_IM       7
`define RTC_INT_ALARM_ENABLE     6
`define RTC_ALM_EN       7
`define RTC_INT_RST      8'h00
`define RTC_ALM_RST      8'h00

// Serial bit counter marks
`define RTC_BIT_LAST     4'h7
`define RTC_BIT_ACK      4'h8

`endif

// >>> rtl/rtcats_top.sv
`timescale 1ns/1ps
`include "rtcats_regs.svh"

module rtcats_top #(
    parameter logic [6:0]  SLAVE_ID     = 7'h52, // Arbitrary value
    parameter int unsigned PULSE_CYCLES = `RTC_PULSE_CYCLES
) (
    input  logic                  core_clk,
    input  logic                  reset,
    input  logic                  scl,
    input  logic                  sda_in,
    output logic                  sda_out,
    output logic                  sda_oe,
    input  logic                  tick_1hz,
    input  rtcats_pkg::rtcats_time_t time_now,
    input  logic                  event_rise,
    input  logic                  event_enable,
    input  logic                  event_out_enable,
    input  logic                  fout_on,
    output logic                  irq_n,
    output logic                  event_detect_out_n
);

    // Pointer step with wrap after the last stamp byte
    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        next_ptr = (p == `RTC_ADDR_LAST) ? `RTC_ADDR_SEC : 8'(p + 8'h01);
    endfunction : next_ptr

    // Alarm byte disabled or equal to its time byte
    function automatic logic byte_hit(input logic [7:0] a, input logic [7:0] t);
        byte_hit = !a[`RTC_ALM_EN] || (a[6:0] == t[6:0]);
    endfunction : byte_hit

    // Link domain (scl)
    logic [1:0]                lrst_sync;
    logic                      start_tog;
    logic                      stop_tog;
    logic                      start_seen;
    logic                      stop_seen;
    rtcats_pkg::rtcats_state_t state;
    logic [3:0]                bitcnt;
    logic [7:0]                rx;
    logic [7:0]                tx;
    logic [7:0]                ptr;
    logic                      master_ack;
    logic                      wr_tog;
    logic                      rd_tog;
    logic                      ptr_tog;
    rtcats_pkg::rtcats_acc_t   wr_acc;
    logic [7:0]                rd_addr;
    logic                      link_rst;
    logic [7:0]                rd_word;

    wire lrst     = lrst_sync[1];
    wire start_ev = start_tog ^ start_seen;
    wire stop_ev  = stop_tog ^ stop_seen;
    wire id_match = (rx[7:1] == SLAVE_ID);

    // Link reset via two flops; START held off meanwhile
    always_ff @(posedge scl) begin
        lrst_sync <= {lrst_sync[0], link_rst};
    end

    // START: data falls while clock high
    always_ff @(negedge sda_in) begin
        if (lrst) begin
            start_tog <= 1'b0;
        end else if (scl) begin
            start_tog <= ~start_tog;
        end
    end

    // STOP: data rises while clock high
    always_ff @(posedge sda_in) begin
        if (lrst) begin
            stop_tog <= 1'b0;
        end else if (scl) begin
            stop_tog <= ~stop_tog;
        end
    end

    // Sample on the rising clock, MSB first
    always_ff @(posedge scl) begin
        if (lrst) begin
            rx         <= 8'h00;
            master_ack <= 1'b0;
        end else if (bitcnt < `RTC_BIT_ACK) begin
            rx <= {rx[6:0], sda_in};
        end else begin
            master_ack <= ~sda_in;
        end
    end

    // Sequencer drives on the falling clock so data moves while low
    always_ff @(negedge scl) begin
        if (lrst) begin
            state      <= rtcats_pkg::ST_IDLE;
            bitcnt     <= 4'h0;
            sda_oe     <= 1'b0;
            sda_out    <= 1'b0;
            tx         <= 8'h00;
            ptr        <= `RTC_ADDR_SEC;
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
            wr_tog     <= 1'b0;
            rd_tog     <= 1'b0;
            ptr_tog    <= 1'b0;
            wr_acc     <= '0;
            rd_addr    <= 8'h00;
        end else begin
            start_seen <= start_tog;
            stop_seen  <= stop_tog;
            if (start_ev) begin
                state  <= rtcats_pkg::ST_ID;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_ev) begin
                state  <= rtcats_pkg::ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                unique case (state)
                    rtcats_pkg::ST_IDLE, rtcats_pkg::ST_IGNORE: begin
                        sda_oe <= 1'b0;
                    end
                    rtcats_pkg::ST_ID: begin
                        if (bitcnt == `RTC_BIT_LAST) begin
                            if (id_match) begin
                                sda_oe <= 1'b1;
                                bitcnt <= `RTC_BIT_ACK;
                            end else begin
                                state <= rtcats_pkg::ST_IGNORE;
                            end
                        end else if (bitcnt == `RTC_BIT_ACK) begin
                            bitcnt <= 4'h0;
                            if (rx[0]) begin
                                // Read: first byte at the pointer
                                state   <= rtcats_pkg::ST_RDATA;
                                tx      <= rd_word;
                                sda_oe  <= ~rd_word[7];
                                rd_addr <= ptr;
                                rd_tog  <= ~rd_tog;
                                ptr     <= next_ptr(ptr);
                                ptr_tog <= ~ptr_tog;
                            end else begin
                                state  <= rtcats_pkg::ST_ADDR;
                                sda_oe <= 1'b0;
                            end
                        end else begin
                            bitcnt <= 4'(bitcnt + 4'h1);
                        end
                    end
                    rtcats_pkg::ST_ADDR: begin
                        if (bitcnt == `RTC_BIT_LAST) begin
                            ptr     <= rx;
                            ptr_tog <= ~ptr_tog;
                            sda_oe  <= 1'b1;
                            bitcnt  <= `RTC_BIT_ACK;
                        end else if (bitcnt == `RTC_BIT_ACK) begin
                            state  <= rtcats_pkg::ST_WDATA;
                            sda_oe <= 1'b0;
                            bitcnt <= 4'h0;
                        end else begin
                            bitcnt <= 4'(bitcnt + 4'h1);
                        end
                    end
                    rtcats_pkg::ST_WDATA: begin
                        if (bitcnt == `RTC_BIT_LAST) begin
                            wr_acc  <= '{addr: ptr, data: rx};
                            wr_tog  <= ~wr_tog;
                            ptr     <= next_ptr(ptr);
                            ptr_tog <= ~ptr_tog;
                            sda_oe  <= 1'b1;
                            bitcnt  <= `RTC_BIT_ACK;
                        end else if (bitcnt == `RTC_BIT_ACK) begin
                            sda_oe <= 1'b0;
                            bitcnt <= 4'h0;
                        end else begin
                            bitcnt <= 4'(bitcnt + 4'h1);
                        end
                    end
                    rtcats_pkg::ST_RDATA: begin
                        if (bitcnt == `RTC_BIT_LAST) begin
                            sda_oe <= 1'b0; // Master acks in the ninth clock
                            bitcnt <= `RTC_BIT_ACK;
                        end else if (bitcnt == `RTC_BIT_ACK) begin
                            bitcnt <= 4'h0;
                            if (master_ack) begin
                                tx      <= rd_word;
                                sda_oe  <= ~rd_word[7];
                                rd_addr <= ptr;
                                rd_tog  <= ~rd_tog;
                                ptr     <= next_ptr(ptr);
                                ptr_tog <= ~ptr_tog;
                            end else begin
                                state <= rtcats_pkg::ST_IGNORE;
                            end
                        end else begin
                            tx     <= {tx[6:0], 1'b0};
                            sda_oe <= ~tx[6];
                            bitcnt <= 4'(bitcnt + 4'h1);
                        end
                    end
                    default: begin
                        state  <= rtcats_pkg::ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Core domain (core_clk)
    logic [2:0]                 wr_sync;
    logic [2:0]                 rd_sync;
    logic [2:0]                 ptr_sync;
    logic [7:0]                 core_ptr;
    logic                       tick_d;
    logic                       auto_clear_on_read;
    logic                       alarm_flag;
    logic                       event_flag;
    logic [7:0]                 int_ctrl;
    logic [7:0]                 alarm_reg [6];
    logic [7:0]                 user_reg  [2];
    logic [7:0]                 stamp_reg [6];
    logic [`RTC_PULSE_W-1:0]    pulse_cnt;

    // Toggles cross in two flops, third marks the edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_sync  <= 3'h0;
            rd_sync  <= 3'h0;
            ptr_sync <= 3'h0;
            link_rst <= 1'b1;
        end else begin
            wr_sync  <= {wr_sync[1:0], wr_tog};
            rd_sync  <= {rd_sync[1:0], rd_tog};
            ptr_sync <= {ptr_sync[1:0], ptr_tog};
            link_rst <= 1'b0;
        end
    end

    wire wr_strobe  = wr_sync[2] ^ wr_sync[1];
    wire rd_strobe  = rd_sync[2] ^ rd_sync[1];
    wire ptr_strobe = ptr_sync[2] ^ ptr_sync[1];

    // Write decode; link words are stable once the toggle lands
    wire [7:0] wa        = wr_acc.addr;
    wire [7:0] wd        = wr_acc.data;
    wire       wr_status = wr_strobe && (wa == `RTC_ADDR_STATUS);
    wire       wr_int    = wr_strobe && (wa == `RTC_ADDR_INT);
    wire       wr_alarm  = wr_strobe && (wa >= `RTC_ADDR_ALM0) && (wa <= `RTC_ADDR_ALM5);
    wire       wr_user0  = wr_strobe && (wa == `RTC_ADDR_USER0);
    wire       wr_user1  = wr_strobe && (wa == `RTC_ADDR_USER1);
    wire [2:0] alm_idx   = 3'(wa - `RTC_ADDR_ALM0);

    // Control bits
    wire alarm_enable       = int_ctrl[`RTC_INT_ALARM_ENABLE];
    wire repeat_pulse_select = int_ctrl[`RTC_INT_IM];
    wire alarm_live         = alarm_enable && !fout_on;

    // Alarm compare, no year byte
    wire [7:0] alm_time [6];
    assign alm_time[0] = time_now.sec;
    assign alm_time[1] = time_now.min;
    assign alm_time[2] = time_now.hour;
    assign alm_time[3] = time_now.date;
    assign alm_time[4] = time_now.month;
    assign alm_time[5] = time_now.wday;

    wire [5:0] hit_bits;
    wire [5:0] en_bits;
    for (genvar i = 0; i < 6; i++) begin : g_cmp
        assign hit_bits[i] = byte_hit(alarm_reg[i], alm_time[i]);
        assign en_bits[i]  = alarm_reg[i][`RTC_ALM_EN];
    end

    // Once per second update, on the new time
    wire alarm_fire = tick_d && alarm_live && (|en_bits) && (&hit_bits);

    wire st_read_clr = rd_strobe && (rd_addr == `RTC_ADDR_STATUS) && auto_clear_on_read;
    wire alm_clr     = (wr_status && !wd[`RTC_ST_ALM]) || st_read_clr;
    wire evt_clr     = wr_status && !wd[`RTC_ST_EVT];
    wire evt_take    = event_rise && event_enable && !event_flag;

    // Status flags; a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tick_d             <= 1'b0;
            alarm_flag         <= 1'b0;
            event_flag         <= 1'b0;
            auto_clear_on_read <= 1'b0;
        end else begin
            tick_d <= tick_1hz;
            if (alarm_fire) begin
                alarm_flag <= 1'b1;
            end else if (alm_clr) begin
                alarm_flag <= 1'b0;
            end
            if (evt_take) begin
                event_flag <= 1'b1;
            end else if (evt_clr) begin
                event_flag <= 1'b0;
            end
            if (wr_status) begin
                auto_clear_on_read <= wd[`RTC_ST_AUTO_CLEAR_ON_READ];
            end
        end
    end

    // Control and alarm bytes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            int_ctrl <= `RTC_INT_RST;
            for (int i = 0; i < 6; i++) begin
                alarm_reg[i] <= `RTC_ALM_RST;
            end
        end else begin
            if (wr_int) begin
                int_ctrl <= wd;
            end
            if (wr_alarm) begin
                alarm_reg[alm_idx] <= wd;
            end
        end
    end

    // No reset: user bytes survive on the backup supply
    always_ff @(posedge core_clk) begin
        if (wr_user0) begin
            user_reg[0] <= wd;
        end
        if (wr_user1) begin
            user_reg[1] <= wd;
        end
    end

    // Stamps: loaded only by a taken event, never reset
    always_ff @(posedge core_clk) begin
        if (evt_take) begin
            stamp_reg[0] <= time_now.sec;
            stamp_reg[1] <= time_now.min;
            stamp_reg[2] <= time_now.hour;
            stamp_reg[3] <= time_now.date;
            stamp_reg[4] <= time_now.month;
            stamp_reg[5] <= time_now.year;
        end
    end

    // Read mux; unmapped addresses read zero
    wire [7:0] status_rd = {auto_clear_on_read, 1'b0, event_flag, alarm_flag, 4'h0};
    wire [7:0] time_rd   = 8'(time_now >> (8 * (6 - core_ptr[2:0])));
    wire [7:0] rd_mux =
        (core_ptr <= `RTC_ADDR_WDAY)   ? time_rd :
        (core_ptr == `RTC_ADDR_STATUS) ? status_rd :
        (core_ptr == `RTC_ADDR_INT)    ? int_ctrl :
        (core_ptr >= `RTC_ADDR_ALM0 && core_ptr <= `RTC_ADDR_ALM5)
            ? alarm_reg[3'(core_ptr - `RTC_ADDR_ALM0)] :
        (core_ptr == `RTC_ADDR_USER0)  ? user_reg[0] :
        (core_ptr == `RTC_ADDR_USER1)  ? user_reg[1] :
        (core_ptr >= `RTC_ADDR_STAMP0 && core_ptr <= `RTC_ADDR_LAST)
            ? stamp_reg[3'(core_ptr - `RTC_ADDR_STAMP0)] : 8'h00;

    // Read word follows the pointer within a few core cycles;
    // the link loads it at least a full byte time later
    always_ff @(posedge core_clk) begin
        if (reset) begin
            core_ptr <= `RTC_ADDR_SEC;
            rd_word  <= 8'h00;
        end else begin
            if (ptr_strobe) begin
                core_ptr <= ptr;
            end
            rd_word <= rd_mux;
        end
    end

    // Hold in single mode, timed pulse in repetitive mode
    wire single_hold = alarm_flag && alarm_live && !repeat_pulse_select;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pulse_cnt <= '0;
            irq_n     <= 1'b1;
        end else begin
            if (alarm_fire && repeat_pulse_select) begin
                pulse_cnt <= `RTC_PULSE_W'(PULSE_CYCLES);
            end else if (pulse_cnt != '0) begin
                pulse_cnt <= `RTC_PULSE_W'(pulse_cnt - 1'b1);
            end
            irq_n <= !(single_hold || (pulse_cnt != '0));
        end
    end

    // Event output toggles on each taken event
    always_ff @(posedge core_clk) begin
        if (reset) begin
            event_detect_out_n <= 1'b1;
        end else if (evt_take && event_out_enable) begin
            event_detect_out_n <= ~event_detect_out_n;
        end
    end

endmodule : rtcats_top
